// ### design/brcs_pkg.sv
// package: constants, register map and types of the bridge reset and clock sequencer
// assumes a single 40 MHz ref_clk shared by both ends
package brcs_pkg;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int BUS_RST_TIME_NS = 1_000_000;
  localparam int BUS_RST_CYC     = (BUS_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERST_MIN_NS    = 1_000_000;
  localparam int PERST_MIN_CYC   = (PERST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_LOAD_CYC    = 64;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] REG_BRIDGE_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CLK_OUT_EN  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CLK_STRAP   = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STICKY      = 4'h4;
  localparam logic [ADDR_W-1:0] REG_GPIO_CTRL   = 4'h5;
  localparam logic [ADDR_W-1:0] REG_GPIO_WRITE  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_MSI_CTRL    = 4'h7;

  localparam int BC_SBR_BIT      = 0;
  localparam int CS_SPD_LSB      = 0;
  localparam int CS_OVR_BIT      = 2;
  localparam int ST_LOADING_BIT  = 0;
  localparam int ST_BUSRST_BIT   = 1;
  localparam int ST_BYPASS_BIT   = 2;
  localparam int ST_SPD_LSB      = 4;
  localparam int ST_MASTER_BIT   = 6;
  localparam logic [1:0] CLK_OUT_EN_RST = 2'h3;

  typedef enum logic [1:0] {
    SPD_25 = 2'h0,
    SPD_33 = 2'h1,
    SPD_50 = 2'h2,
    SPD_66 = 2'h3
  } brcs_speed_e;

  // half periods of the bus clock in ref_clk cycles; 40 MHz cannot hit the true rates, so ratios stand in
  localparam int HALF_W = 4;
  localparam logic [HALF_W-1:0] HALF_25 = 4'h4;
  localparam logic [HALF_W-1:0] HALF_33 = 4'h3;
  localparam logic [HALF_W-1:0] HALF_50 = 4'h2;
  localparam logic [HALF_W-1:0] HALF_66 = 4'h1;

  // link clock: 100 MHz reference times 5/4 gives the 125 MHz core clock
  localparam int LINK_REF_MHZ  = 100;
  localparam int LINK_PLL_NUM  = 5;
  localparam int LINK_PLL_DEN  = 4;
  localparam int LINK_CORE_MHZ = LINK_REF_MHZ * LINK_PLL_NUM / LINK_PLL_DEN;
  localparam int SKP_PPM       = 300;
  localparam int EFILL_W       = 4;
  localparam logic [EFILL_W-1:0] EFILL_HIGH = 4'hC;
endpackage

// ### design/brcs_link_if.sv
// interface: upstream reset signalling and configuration access between host and bridge
// assumes both ends run on the same ref_clk
`timescale 1ns/100ps
interface brcs_link_if;
  import brcs_pkg::*;
  logic              fundamental_reset_in_n;
  logic              hot_reset_msg;
  logic              link_lost_state;
  logic              cfg_wr;
  logic              cfg_rd;
  logic [ADDR_W-1:0] cfg_addr;
  logic [DATA_W-1:0] cfg_wdata;
  logic [DATA_W-1:0] cfg_rdata;
  logic              cfg_cpl;
  logic              cfg_retry;

  modport dev (
    input  fundamental_reset_in_n, hot_reset_msg, link_lost_state, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    output cfg_rdata, cfg_cpl, cfg_retry
  );
  modport host (
    output fundamental_reset_in_n, hot_reset_msg, link_lost_state, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    input  cfg_rdata, cfg_cpl, cfg_retry
  );
endinterface

// ### design/brcs_host.sv
// module: upstream end - reset controller plus software access path into the bridge
// assumes software drives the sw_* port on ref_clk, one strobe at a time
`timescale 1ns/100ps
module brcs_host #(
  parameter int PERST_CYCLES = brcs_pkg::PERST_MIN_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  brcs_link_if.host                      lnk,
  input  wire logic                      cold_reset_req,
  input  wire logic                      hot_reset_req,
  input  wire logic                      link_down,
  input  wire logic                      clock_slave_mode,
  input  wire logic                      requests_pending,
  input  wire logic [brcs_pkg::ADDR_W-1:0] sw_addr,
  input  wire logic [brcs_pkg::DATA_W-1:0] sw_wdata,
  input  wire logic                      sw_wr,
  input  wire logic                      sw_rd,
  output logic      [brcs_pkg::DATA_W-1:0] sw_rdata,
  output logic                           sw_retry,
  output logic                           sw_refused,
  output logic                           perst_busy
);
  import brcs_pkg::*;

  localparam int PCNT_W = $clog2(PERST_CYCLES + 1);

  typedef struct packed {
    logic [PCNT_W-1:0] pcnt;
    logic              perst_n;
    logic              hot;
    logic              lost;
    logic              refused;
  } brcs_host_s;

  brcs_host_s q, d;
  logic       refuse;
  logic       wr_ok;

  // setting the bus reset bit with traffic still queued is dropped, not forwarded
  assign refuse = sw_wr && (sw_addr == REG_BRIDGE_CTRL) && sw_wdata[BC_SBR_BIT] && requests_pending;
  assign wr_ok  = sw_wr && !refuse;

  always_comb begin
    d         = q;
    d.hot     = hot_reset_req;
    d.lost    = link_down;
    d.refused = refuse;
    if (!q.perst_n) begin
      if (q.pcnt == PCNT_W'(PERST_CYCLES - 1)) begin
        d.perst_n = 1'b1;
      end else begin
        d.pcnt = q.pcnt + 1'b1;
      end
    end
    if (cold_reset_req) begin
      d.perst_n = 1'b0;
      d.pcnt    = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.fundamental_reset_in_n = q.perst_n;
  assign lnk.hot_reset_msg          = q.hot;
  assign lnk.link_lost_state        = q.lost;
  assign lnk.cfg_wr                 = wr_ok;
  assign lnk.cfg_rd                 = sw_rd;
  assign lnk.cfg_addr               = sw_addr;

  // the strap override word passes as written; in slave mode clock output 0 is forced off
  always_comb begin
    lnk.cfg_wdata = sw_wdata;
    if (clock_slave_mode && (sw_addr == REG_CLK_OUT_EN)) begin
      lnk.cfg_wdata[0] = 1'b0;
    end
  end

  assign sw_rdata   = lnk.cfg_rdata;
  assign sw_retry   = lnk.cfg_retry;
  assign sw_refused = q.refused;
  assign perst_busy = !q.perst_n;
endmodule

// ### design/brcs_dev.sv
// module: bridge end - reset levels 0/1/2, configuration retry window, bus reset and bus clock control
// assumes the link interface is driven on ref_clk except the reset pin, which is synchronised here
`timescale 1ns/100ps
module brcs_dev #(
  parameter int BUS_RST_CYCLES  = brcs_pkg::BUS_RST_CYC,
  parameter int CFG_LOAD_CYCLES = brcs_pkg::CFG_LOAD_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  brcs_link_if.dev                           lnk,
  input  wire logic                          clock_master_strap,
  input  wire logic                          speed66_strap_pin,
  input  wire logic                          dn_req_valid,
  input  wire logic                          dn_req_nonposted,
  input  wire logic [brcs_pkg::EFILL_W-1:0]  elastic_fill,
  output logic                               secondary_bus_reset_out_n,
  output logic      [1:0]                    bus_clock_outputs,
  output brcs_pkg::brcs_speed_e              bus_speed,
  output logic                               pll_bypass,
  output logic                               drain_bus_side,
  output logic                               dn_req_ready,
  output logic                               credit_return,
  output logic                               ur_completion,
  output logic                               skip_drop
);
  import brcs_pkg::*;

  localparam int CNT_W  = $clog2(BUS_RST_CYCLES + 1);
  localparam int LOAD_W = $clog2(CFG_LOAD_CYCLES + 1);

  typedef enum logic [1:0] {
    ST_COLD = 2'h0,
    ST_LOAD = 2'h1,
    ST_RUN  = 2'h3,
    ST_HOT  = 2'h2
  } brcs_state_e;

  typedef struct packed {
    logic              perst_m;
    logic              perst_s;
    logic              master_m;
    logic              master_s;
    logic              m66_m;
    logic              m66_s;
    brcs_state_e       st;
    logic [CNT_W-1:0]  rst_cnt;
    logic [LOAD_W-1:0] load_cnt;
    logic              sbr;
    logic [1:0]        clk_en;
    logic              ovr;
    brcs_speed_e       ovr_spd;
    brcs_speed_e       spd;
    logic              bypass;
    logic              is_master;
    logic [DATA_W-1:0] sticky;
    logic [DATA_W-1:0] gpio_ctrl;
    logic [DATA_W-1:0] gpio_wr;
    logic [DATA_W-1:0] msi_ctrl;
    logic [DATA_W-1:0] rdata;
    logic              cpl;
    logic              retry;
    logic              bus_rst_n;
    logic [HALF_W-1:0] div_cnt;
    logic              clk_lvl;
    logic [1:0]        clk_out;
    logic              drain;
    logic              credit;
    logic              ur;
    logic              skip_drop;
  } brcs_dev_s;

  brcs_dev_s q, d;
  logic      loading;

  assign loading = (q.st != ST_RUN);

  always_comb begin
    logic [DATA_W-1:0] rw;
    logic [HALF_W-1:0] half;
    rw   = '0;
    half = HALF_25;
    d    = q;
    // the first stage of each synchroniser feeds only the second
    d.perst_m  = lnk.fundamental_reset_in_n;
    d.perst_s  = q.perst_m;
    d.master_m = clock_master_strap;
    d.master_s = q.master_m;
    d.m66_m    = speed66_strap_pin;
    d.m66_s    = q.m66_m;
    d.cpl      = 1'b0;
    d.retry    = 1'b0;
    d.rdata    = '0;
    d.drain    = 1'b0;
    d.credit   = 1'b0;
    d.ur       = 1'b0;
    // rx elastic data is clocked into the 125 MHz domain upstream of here; only skip dropping is decided
    d.skip_drop = (elastic_fill >= EFILL_HIGH);

    case (lnk.cfg_addr)
      REG_BRIDGE_CTRL: rw[BC_SBR_BIT] = q.sbr;
      REG_CLK_OUT_EN:  rw[1:0] = q.clk_en;
      REG_CLK_STRAP: begin
        rw[CS_OVR_BIT]        = q.ovr;
        rw[CS_SPD_LSB +: 2]   = q.ovr_spd;
      end
      REG_STATUS: begin
        rw[ST_LOADING_BIT]    = loading;
        rw[ST_BUSRST_BIT]     = !q.bus_rst_n;
        rw[ST_BYPASS_BIT]     = q.bypass;
        rw[ST_SPD_LSB +: 2]   = q.spd;
        rw[ST_MASTER_BIT]     = q.is_master;
      end
      REG_STICKY:      rw = q.sticky;
      REG_GPIO_CTRL:   rw = q.gpio_ctrl;
      REG_GPIO_WRITE:  rw = q.gpio_wr;
      REG_MSI_CTRL:    rw = q.msi_ctrl;
      default:         rw = '0;
    endcase

    if (lnk.cfg_rd || lnk.cfg_wr) begin
      d.cpl   = 1'b1;
      d.retry = loading;
      if (lnk.cfg_rd && !loading) begin
        d.rdata = rw;
      end
    end
    if (lnk.cfg_wr && !loading) begin
      case (lnk.cfg_addr)
        REG_BRIDGE_CTRL: d.sbr = lnk.cfg_wdata[BC_SBR_BIT];
        REG_CLK_OUT_EN:  d.clk_en = lnk.cfg_wdata[1:0];
        REG_CLK_STRAP: begin
          d.ovr     = lnk.cfg_wdata[CS_OVR_BIT];
          d.ovr_spd = brcs_speed_e'(lnk.cfg_wdata[CS_SPD_LSB +: 2]);
        end
        REG_STICKY:      d.sticky = lnk.cfg_wdata;
        REG_GPIO_CTRL:   d.gpio_ctrl = lnk.cfg_wdata;
        REG_GPIO_WRITE:  d.gpio_wr = lnk.cfg_wdata;
        REG_MSI_CTRL:    d.msi_ctrl = lnk.cfg_wdata;
        default: ;
      endcase
    end

    // level 2: the control registers are left alone and no reload happens
    if (d.sbr && !q.sbr) begin
      d.drain   = 1'b1;
      d.rst_cnt = CNT_W'(BUS_RST_CYCLES);
    end else if (q.rst_cnt != '0) begin
      d.rst_cnt = q.rst_cnt - 1'b1;
    end
    if (q.sbr && dn_req_valid) begin
      d.credit = 1'b1;
      d.ur     = dn_req_nonposted;
    end

    case (q.st)
      ST_COLD: begin
        if (q.perst_s) begin
          d.st = ST_LOAD;
        end
      end
      ST_HOT: begin
        if (!lnk.link_lost_state) begin
          d.st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (q.load_cnt == '0) begin
          d.st = ST_RUN;
        end else begin
          d.load_cnt = q.load_cnt - 1'b1;
        end
      end
      ST_RUN: ;
      default: d.st = ST_COLD;
    endcase
    if ((lnk.hot_reset_msg || lnk.link_lost_state) && (q.st != ST_COLD)) begin
      d.st = ST_HOT;
    end
    if (!q.perst_s) begin
      d.st = ST_COLD;
    end

    // the 1 ms countdown starts only once the reset state is left
    if ((d.st == ST_COLD) || (d.st == ST_HOT)) begin
      d.sbr      = 1'b0;
      d.clk_en   = CLK_OUT_EN_RST;
      d.ovr      = 1'b0;
      d.ovr_spd  = SPD_25;
      d.spd      = SPD_25;
      d.bypass   = 1'b1;
      d.rst_cnt  = CNT_W'(BUS_RST_CYCLES);
      d.load_cnt = LOAD_W'(CFG_LOAD_CYCLES);
      if (d.st == ST_COLD) begin
        d.sticky    = '0;
        d.gpio_ctrl = '0;
        d.gpio_wr   = '0;
        d.msi_ctrl  = '0;
      end
    end

    d.bus_rst_n = !((d.st == ST_COLD) || (d.st == ST_HOT) || (d.rst_cnt != '0) || d.sbr);
    if (d.bus_rst_n && !q.bus_rst_n) begin
      d.is_master = q.master_s;
      if (q.master_s) begin
        d.bypass = 1'b0;
        if (q.ovr) begin
          d.spd = q.ovr_spd;
        end else begin
          d.spd = q.m66_s ? SPD_66 : SPD_33;
        end
      end
    end

    case (q.spd)
      SPD_33:  half = HALF_33;
      SPD_50:  half = HALF_50;
      SPD_66:  half = HALF_66;
      default: half = HALF_25;
    endcase
    if (q.bypass) begin
      half = HALF_25;
    end
    if (q.div_cnt == '0) begin
      d.div_cnt = half - 1'b1;
      d.clk_lvl = !q.clk_lvl;
    end else begin
      d.div_cnt = q.div_cnt - 1'b1;
    end
    // a slave-mode bridge has no clock of its own to drive
    d.clk_out = q.is_master ? (q.clk_en & {2{q.clk_lvl}}) : 2'h0;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.cfg_rdata              = q.rdata;
  assign lnk.cfg_cpl                = q.cpl;
  assign lnk.cfg_retry              = q.retry;
  assign secondary_bus_reset_out_n  = q.bus_rst_n;
  assign bus_clock_outputs          = q.clk_out;
  assign bus_speed                  = q.spd;
  assign pll_bypass                 = q.bypass;
  assign drain_bus_side             = q.drain;
  assign dn_req_ready               = q.sbr;
  assign credit_return              = q.credit;
  assign ur_completion              = q.ur;
  assign skip_drop                  = q.skip_drop;
endmodule

// ### verification/brcs_link_monitor.sv
// checker: timing relations on the link between the host end and the bridge end
// assumes one ref_clk for both ends; instantiated beside the interface
`timescale 1ns/100ps
module brcs_link_monitor #(
  parameter int PERST_CYCLES = brcs_pkg::PERST_MIN_CYC
) (
  input wire logic                        ref_clk,
  input wire logic                        reset_n,
  input wire logic                        fundamental_reset_in_n,
  input wire logic                        hot_reset_msg,
  input wire logic                        link_lost_state,
  input wire logic                        cfg_wr,
  input wire logic                        cfg_rd,
  input wire logic [brcs_pkg::DATA_W-1:0] cfg_rdata,
  input wire logic                        cfg_cpl,
  input wire logic                        cfg_retry
);
  import brcs_pkg::*;
  logic [15:0] low_q;
  logic [15:0] low_d;
  // length of the current low phase of the reset pin
  always_comb low_d = fundamental_reset_in_n ? 16'h0000 : low_q + 16'h0001;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) low_q <= 16'h0000;
    else low_q <= low_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_strobe; cfg_wr || cfg_rd; endsequence
  sequence s_up_rd; $rose(fundamental_reset_in_n) ##[0:4] cfg_rd; endsequence
  sequence s_hot_rd; hot_reset_msg ##[1:3] cfg_rd; endsequence
  property p_answer; s_strobe |=> cfg_cpl; endproperty
  property p_no_stray; cfg_cpl |-> $past(cfg_wr || cfg_rd); endproperty
  property p_one_strobe; !(cfg_wr && cfg_rd); endproperty
  property p_retry_cpl; cfg_retry |-> cfg_cpl; endproperty
  property p_retry_zero; cfg_cpl && cfg_retry |-> cfg_rdata == '0; endproperty
  property p_cold_retry; !fundamental_reset_in_n && $past(!fundamental_reset_in_n, 3) && cfg_rd |=> cfg_retry; endproperty
  property p_load_retry; s_up_rd |=> cfg_retry; endproperty
  property p_hot_retry; s_hot_rd |=> cfg_retry; endproperty
  property p_lost_retry; link_lost_state && $past(link_lost_state) && cfg_rd |=> cfg_retry; endproperty
  property p_perst_min; $rose(fundamental_reset_in_n) |-> low_q >= PERST_CYCLES; endproperty
  property p_hot_pulse; hot_reset_msg |=> !hot_reset_msg; endproperty
  a_answer: assert property (p_answer) else $error("request without completion");
  a_no_stray: assert property (p_no_stray) else $error("completion without request");
  a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
  a_retry_cpl: assert property (p_retry_cpl) else $error("retry outside completion");
  a_retry_zero: assert property (p_retry_zero) else $error("retried read carries data");
  a_cold_retry: assert property (p_cold_retry) else $error("no retry in cold reset");
  a_load_retry: assert property (p_load_retry) else $error("no retry while loading");
  a_hot_retry: assert property (p_hot_retry) else $error("no retry after hot reset");
  a_lost_retry: assert property (p_lost_retry) else $error("no retry while link lost");
  a_perst_min: assert property (p_perst_min) else $error("reset pin pulse too short");
  a_hot_pulse: assert property (p_hot_pulse) else $error("hot reset message too long");
endmodule

// ### verification/bridge_reset_clock_sequencer_tb_top.sv
// testbench: host and bridge ends joined by the link, driven through the software port
// assumes shortened reset counts so the run stays a few hundred cycles
`timescale 1ns/100ps
module bridge_reset_clock_sequencer_tb_top;
  import brcs_pkg::*;
  localparam int PC = 10;
  localparam int BC = 20;
  typedef struct packed {logic [31:0] d; logic r; logic rd;} brcs_exp_s;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cold_reset_req = 1'b0, hot_reset_req = 1'b0, link_down = 1'b0, slave = 1'b0, pend = 1'b0;
  logic        sw_wr = 1'b0, sw_rd = 1'b0, s66 = 1'b1, dn_v = 1'b0, dn_np = 1'b0, mst = 1'b1;
  logic [3:0]  sw_addr = 4'h0, fill = 4'h0;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, v [6];
  logic        sw_retry, sw_refused, perst_busy, bus_rst_n, byp, drain, dn_rdy, cred, ur, skip, z;
  logic [1:0]  clk_o;
  brcs_speed_e spd;
  brcs_exp_s   q [$];
  brcs_exp_s   e;
  int          fails = 0, n_checks = 0, cyc = 0, t0, k;
  always #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) cyc <= cyc + 1;
  brcs_link_if brcs_link_if_i ();
  brcs_host #(.PERST_CYCLES(PC)) brcs_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(brcs_link_if_i),
    .cold_reset_req(cold_reset_req), .hot_reset_req(hot_reset_req), .link_down(link_down),
    .clock_slave_mode(slave), .requests_pending(pend), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sw_retry(sw_retry), .sw_refused(sw_refused), .perst_busy(perst_busy));
  brcs_dev #(.BUS_RST_CYCLES(BC), .CFG_LOAD_CYCLES(4)) brcs_dev_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .lnk(brcs_link_if_i), .clock_master_strap(mst), .speed66_strap_pin(s66), .dn_req_valid(dn_v),
    .dn_req_nonposted(dn_np), .elastic_fill(fill), .secondary_bus_reset_out_n(bus_rst_n),
    .bus_clock_outputs(clk_o), .bus_speed(spd), .pll_bypass(byp), .drain_bus_side(drain), .dn_req_ready(dn_rdy),
    .credit_return(cred), .ur_completion(ur), .skip_drop(skip));
  brcs_link_monitor #(.PERST_CYCLES(PC)) brcs_link_monitor_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .fundamental_reset_in_n(brcs_link_if_i.fundamental_reset_in_n), .hot_reset_msg(brcs_link_if_i.hot_reset_msg),
    .link_lost_state(brcs_link_if_i.link_lost_state), .cfg_wr(brcs_link_if_i.cfg_wr), .cfg_rd(brcs_link_if_i.cfg_rd),
    .cfg_rdata(brcs_link_if_i.cfg_rdata), .cfg_cpl(brcs_link_if_i.cfg_cpl), .cfg_retry(brcs_link_if_i.cfg_retry));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // for a read d is the expected data, for a write the data sent
  task automatic acc(logic w, logic [3:0] a, logic [31:0] d, logic r);
    @(posedge ref_clk);
    sw_wr <= w;
    sw_rd <= !w;
    sw_addr <= a;
    sw_wdata <= d;
    q.push_back('{d, r, !w});
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
  endtask
  // span from t0 to the release of the bus reset must be lo .. lo+8 cycles
  task automatic bus_win(int t0, int lo);
    k = 0;
    while (bus_rst_n !== 1'b1 && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    chk("bus reset span", (cyc - t0 >= lo) && (cyc - t0 <= lo + 8), 1);
    repeat (2) @(negedge ref_clk);
  endtask
  always @(negedge ref_clk) begin
    if (brcs_link_if_i.cfg_cpl === 1'b1) begin
      if (q.size() == 0) chk("unexpected completion", 1, 0);
      else begin
        e = q.pop_front();
        chk("retry", sw_retry, e.r);
        if (e.rd) chk("read data", sw_rdata, e.d);
      end
    end
  end
  initial begin
    #500000;
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hAFC64278));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    t0 = cyc;
    repeat (PC + 2) @(posedge ref_clk);
    acc(0, REG_STATUS, 0, 1);
    acc(1, REG_STICKY, 32'h55, 1);
    chk("bypass early", byp, 1);
    bus_win(t0, PC + BC);
    chk("speed", spd, SPD_66);
    chk("bypass", byp, 0);
    acc(0, REG_STATUS, 32'h70, 0);
    acc(0, REG_STICKY, 0, 0);
    for (int i = 0; i < 6; i++) begin
      v[i] = $urandom();
      acc(1, 4'(i < 2 ? i + 1 : i + 2), v[i], 0);
    end
    hot_reset_req <= 1'b1;
    @(posedge ref_clk);
    hot_reset_req <= 1'b0;
    t0 = cyc;
    acc(0, REG_STATUS, 0, 1);
    chk("bus reset hot", bus_rst_n, 0);
    bus_win(t0, BC);
    for (int i = 0; i < 6; i++) acc(0, 4'(i < 2 ? i + 1 : i + 2), i == 0 ? 32'(CLK_OUT_EN_RST) : i == 1 ? 0 : v[i], 0);
    link_down <= 1'b1;
    repeat (4) @(posedge ref_clk);
    acc(0, REG_STATUS, 0, 1);
    link_down <= 1'b0;
    bus_win(cyc, BC);
    @(posedge ref_clk);
    s66 <= 1'b0;
    cold_reset_req <= 1'b1;
    @(posedge ref_clk);
    cold_reset_req <= 1'b0;
    t0 = cyc;
    repeat (4) @(posedge ref_clk);
    chk("reset pin held", perst_busy, 1);
    acc(0, REG_STATUS, 0, 1);
    bus_win(t0, PC + BC);
    chk("reset pin free", perst_busy, 0);
    chk("speed strap low", spd, SPD_33);
    acc(0, REG_STICKY, 0, 0);
    acc(0, REG_MSI_CTRL, 0, 0);
    for (int c = 0; c < 4; c++) begin
      acc(1, REG_CLK_STRAP, 32'h4 | 32'(c), 0);
      acc(1, REG_BRIDGE_CTRL, 1, 0);
      t0 = cyc;
      @(negedge ref_clk);
      chk("drain", drain, 1);
      chk("bus reset low", bus_rst_n, 0);
      chk("ready", dn_rdy, 1);
      @(posedge ref_clk);
      dn_v <= 1'b1;
      dn_np <= c[0];
      @(posedge ref_clk);
      dn_v <= 1'b0;
      @(negedge ref_clk);
      chk("credit", cred, 1);
      chk("unsupported", ur, c[0]);
      // the long hold shows the bit, not the count, ending the reset
      if (c >= 2) begin
        repeat (BC + 10) @(posedge ref_clk);
        chk("bus reset held", bus_rst_n, 0);
        t0 = cyc - BC;
      end
      acc(1, REG_BRIDGE_CTRL, 0, 0);
      bus_win(t0, BC);
      chk("speed override", spd, c);
      chk("ready off", dn_rdy, 0);
    end
    acc(1, REG_CLK_OUT_EN, 2, 0);
    repeat (3) @(posedge ref_clk);
    k = 0;
    z = 1'b0;
    repeat (16) begin
      @(negedge ref_clk);
      k += clk_o[1];
      z |= clk_o[0];
    end
    chk("clock 0 off", z, 0);
    chk("clock 1 highs", k, 8);
    @(posedge ref_clk);
    slave <= 1'b1;
    acc(1, REG_CLK_OUT_EN, 3, 0);
    acc(0, REG_CLK_OUT_EN, 2, 0);
    pend <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b1;
    sw_addr <= REG_BRIDGE_CTRL;
    sw_wdata <= 32'h1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    @(negedge ref_clk);
    chk("refused", sw_refused, 1);
    repeat (2) @(negedge ref_clk);
    chk("no bus reset", bus_rst_n, 1);
    @(posedge ref_clk);
    pend <= 1'b0;
    for (int f = 10; f < 14; f++) begin
      @(posedge ref_clk);
      fill <= 4'(f);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("skip drop", skip, f >= EFILL_HIGH);
    end
    // slave strap: a level-2 reset must drop master duties and stop both clocks
    @(posedge ref_clk);
    mst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    acc(1, REG_BRIDGE_CTRL, 1, 0);
    t0 = cyc;
    acc(1, REG_BRIDGE_CTRL, 0, 0);
    bus_win(t0, BC);
    acc(0, REG_STATUS, 32'h30, 0);
    z = 1'b0;
    repeat (8) begin
      @(negedge ref_clk);
      z |= |clk_o;
    end
    chk("slave clocks off", z, 0);
    chk("link clock", LINK_CORE_MHZ, 125);
    chk("open notes", q.size(), 0);
    end_sim();
  end
endmodule
